/* include/pris_pkg.sv */
/*
 * pris_pkg: constants, word map and types for the processor reset and
 * restart state block.
 * assumes: a single 20 MHz clock and a 32-bit word-addressed AXI4-Lite map.
 */
`default_nettype none

package pris_pkg;

    // ----------------------------------------------------------------
    // word map (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam int NUM_WORDS = 106;        // architectural words held in the array
    localparam logic [6:0] IDX_GPR = 7'h00;        // eight general_regs
    localparam logic [6:0] IDX_FOURTH_GPR = 7'h03; // fourth_data_gpr
    localparam logic [6:0] IDX_IP = 7'h08;
    localparam logic [6:0] IDX_FLAGS = 7'h09;
    localparam logic [6:0] IDX_CS = 7'h0a;         // selector/rights, base, limit
    localparam logic [6:0] IDX_SEG_DATA = 7'h0d;   // five segments, three words each
    localparam logic [6:0] IDX_GDTR = 7'h1c;       // gdtr base, limit, idtr base, limit
    localparam logic [6:0] IDX_LDTR = 7'h20;       // ldtr then tr, three words each
    localparam logic [6:0] IDX_CR0 = 7'h26;
    localparam logic [6:0] IDX_CR2 = 7'h27;
    localparam logic [6:0] IDX_CR3 = 7'h28;
    localparam logic [6:0] IDX_CR4 = 7'h29;
    localparam logic [6:0] IDX_BKPT = 7'h2a;       // four breakpoint_addr_regs
    localparam logic [6:0] IDX_DBG_STAT = 7'h2e;
    localparam logic [6:0] IDX_DBG_CTL = 7'h2f;
    localparam logic [6:0] IDX_FPU_STK = 7'h30;    // 8 x 80 bits, three words each
    localparam logic [6:0] IDX_MEDIA = 7'h48;      // 8 x 64 bits
    localparam logic [6:0] IDX_FPU_CWSW = 7'h58;   // control word low, status word high
    localparam logic [6:0] IDX_FPU_TAG = 7'h59;
    localparam logic [6:0] IDX_FPU_IP = 7'h5a;     // two words
    localparam logic [6:0] IDX_FPU_DP = 7'h5c;     // two words
    localparam logic [6:0] IDX_FPU_OPC = 7'h5e;
    localparam logic [6:0] IDX_TSC_LO = 7'h5f;
    localparam logic [6:0] IDX_TSC_HI = 7'h60;
    localparam logic [6:0] IDX_SERIAL_OFF = 7'h61;
    localparam logic [6:0] IDX_ID_SIG = 7'h62;
    localparam logic [6:0] IDX_VENDOR = 7'h63;     // three words
    localparam logic [6:0] IDX_FEAT_MASK = 7'h66;
    localparam logic [6:0] IDX_POWER = 7'h67;      // two words
    localparam logic [6:0] IDX_A20 = 7'h69;        // bit 0 set = line 20 masked
    localparam logic [6:0] IDX_MODE = 7'h6a;       // cpu mode control
    localparam logic [6:0] IDX_STATUS = 7'h6b;     // read-only block status

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] IP_RESET = 32'h0000_fff0;
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
    localparam logic [15:0] SEL_CS = 16'hf000;
    localparam logic [31:0] BASE_CS = 32'hffff_0000;
    localparam logic [15:0] AR_CS = 16'h009b;
    localparam logic [15:0] AR_DATA = 16'h0093;
    localparam logic [15:0] AR_SYS = 16'h0082;
    localparam logic [31:0] SEG_LIMIT = 32'h0000_ffff;
    localparam logic [31:0] CR0_HARD = 32'h6000_0010;
    localparam logic [31:0] CR0_KEEP_MASK = 32'h6000_0000; // bits 30 and 29
    localparam logic [31:0] DBG_STAT_RESET = 32'hffff_0ff0;
    localparam logic [31:0] DBG_CTL_RESET = 32'h0000_0400;
    localparam logic [31:0] FPU_CWSW_RESET = 32'h0000_0040;
    localparam logic [31:0] FPU_TAG_RESET = 32'h0000_5555;
    localparam logic [31:0] FEAT_MASK_RESET = 32'hffff_feff;
    localparam logic [31:0] POWER_RESET = 32'h0000_0064;

    // ----------------------------------------------------------------
    // modes, responses, types
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_REAL = 2'h0;
    localparam logic [1:0] MODE_V86 = 2'h1;
    localparam logic [1:0] MODE_PROT = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {S_HARD, S_WARM, S_RUN} pris_state_t;

    typedef struct packed {
        logic in_range;
        logic [6:0] idx;
        logic [31:0] data;
        logic [3:0] strb;
    } pris_wr_t;

    // hard-reset value of each word; identity words are overridden in the top
    function automatic logic [31:0] hard_value(input int idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (idx == int'(IDX_IP)) v = IP_RESET;
        else if (idx == int'(IDX_FLAGS)) v = FLAGS_RESET;
        else if (idx == int'(IDX_CS)) v = {AR_CS, SEL_CS};
        else if (idx == int'(IDX_CS) + 1) v = BASE_CS;
        else if (idx == int'(IDX_CS) + 2) v = SEG_LIMIT;
        else if (idx >= int'(IDX_SEG_DATA) && idx < int'(IDX_GDTR))
        begin
            if ((idx - int'(IDX_SEG_DATA)) % 3 == 0) v = {AR_DATA, 16'h0000};
            else if ((idx - int'(IDX_SEG_DATA)) % 3 == 2) v = SEG_LIMIT;
        end
        else if (idx >= int'(IDX_GDTR) && idx < int'(IDX_LDTR))
        begin
            if ((idx - int'(IDX_GDTR)) % 2 == 1) v = SEG_LIMIT;
        end
        else if (idx >= int'(IDX_LDTR) && idx < int'(IDX_CR0))
        begin
            if ((idx - int'(IDX_LDTR)) % 3 == 0) v = {AR_SYS, 16'h0000};
            else if ((idx - int'(IDX_LDTR)) % 3 == 2) v = SEG_LIMIT;
        end
        else if (idx == int'(IDX_CR0)) v = CR0_HARD;
        else if (idx == int'(IDX_DBG_STAT)) v = DBG_STAT_RESET;
        else if (idx == int'(IDX_DBG_CTL)) v = DBG_CTL_RESET;
        else if (idx == int'(IDX_FPU_CWSW)) v = FPU_CWSW_RESET;
        else if (idx == int'(IDX_FPU_TAG)) v = FPU_TAG_RESET;
        else if (idx == int'(IDX_FEAT_MASK)) v = FEAT_MASK_RESET;
        else if (idx == int'(IDX_POWER) || idx == int'(IDX_POWER) + 1) v = POWER_RESET;
        return v;
    endfunction

endpackage

`default_nettype wire

/* hdl/pris_top.sv */
/*
 * pris_top: holds the processor's architectural state and loads it on a
 * hard reset, a warm restart or a shutdown; software reaches every word
 * over an AXI4-Lite slave.
 * assumes: RST_N and WARM_RESTART come from the chipset synchronous to CLK;
 * SHUTDOWN comes from the core; one AXI master.
 */
// What this block does
// (RULE_01) hard reset loads everything; warm restart loads most and keeps some units
// (RULE_02) shutdown has no own state; it restarts exactly like warm restart
// (RULE_03) general registers except the fourth read zero after either reset
// (RULE_04) fourth register: signature on hard reset, low half of signature word on warm
// (RULE_05) instruction pointer gets fff0, flags get 0002 after either reset
// (RULE_06) code segment gets f000 selector, ffff0000 base, 64 KB limit, rights 009b
// (RULE_07) stack and data segments: zero selector and base, ffff limit, rights 0093
// (RULE_08) table registers zero base, ffff limit; local and task rights 0082
// (RULE_09) base control register 60000010 on hard; warm keeps bits 30 and 29
// (RULE_10) fault address, page base, extended control and breakpoints clear to zero
// (RULE_11) debug status gets ffff0ff0 and debug control 00000400 after either reset
// (RULE_12) hard reset loads fpu and media state (control word 0040, tag 5555, rest zero); warm restart leaves it alone
// (RULE_13) timestamp clears on hard reset and keeps counting through warm restart
// (RULE_14) feature mask loads fffffeff on hard reset, kept across warm restart
// (RULE_15) power register loads 64 in both halves on hard reset, kept on warm
// (RULE_16) serial-number-off word takes a config strap on hard reset, kept on warm
// (RULE_17) vendor string words load fixed values on hard reset, kept on warm
// (RULE_18) hard reset unmasks address line 20; warm restart leaves it unchanged
// (RULE_19) caches invalidated by hard reset only; translation buffers by both
// (RULE_20) code segment writes allowed in real and v86 mode, refused in protected
// (RULE_21) all values are in place before fetch is enabled again
`timescale 1ns/10ps
`default_nettype none

module pris_top #(
    parameter logic [31:0] SIGNATURE = 32'h0000_0a5a,  // arbitrary value
    parameter logic [31:0] VENDOR_1 = 32'h1111_1111,   // arbitrary value
    parameter logic [31:0] VENDOR_2 = 32'h2222_2222,   // arbitrary value
    parameter logic [31:0] VENDOR_3 = 32'h3333_3333    // arbitrary value
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic WARM_RESTART,
    input wire logic SHUTDOWN,
    input wire logic SERIAL_OFF_CFG,
    output logic FETCH_EN,
    output logic A20_MASKED,
    output logic CACHE_INV,
    output logic TLB_INV,
    input wire logic [31:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [31:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0] arch_mem [pris_pkg::NUM_WORDS];
    logic [1:0] mode_reg;
    pris_pkg::pris_state_t state_reg;
    logic fetch_en_reg;
    logic cache_inv_reg;
    logic tlb_inv_reg;
    pris_pkg::pris_wr_t wr_req_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic warm_req;
    logic wr_fire;
    logic cs_hit;
    logic wr_ok;
    logic [6:0] rd_idx;
    logic rd_in_range;
    logic [31:0] rd_value;
    logic rd_hit;
    logic [31:0] status_word;

    // shutdown has no state of its own: it is folded into the warm request
    assign warm_req = WARM_RESTART | SHUTDOWN; // RULE_02

    // ----------------------------------------------------------------
    // restart sequencing
    // ----------------------------------------------------------------
    // fetch stays off through any reset; it opens on the edge after release,
    // by which time every word below has already been loaded
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            state_reg <= pris_pkg::S_HARD;
            fetch_en_reg <= 1'b0;
        end
        else
        begin
            state_reg <= warm_req ? pris_pkg::S_WARM : pris_pkg::S_RUN;
            fetch_en_reg <= ~warm_req; // RULE_21
        end
    end

    // cache flush only on hard reset; translation buffers on both kinds
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            cache_inv_reg <= 1'b1; // RULE_19
            tlb_inv_reg <= 1'b1;
        end
        else
        begin
            cache_inv_reg <= 1'b0;
            tlb_inv_reg <= warm_req; // RULE_19
        end
    end

    // ----------------------------------------------------------------
    // architectural word array
    // ----------------------------------------------------------------
    // words below the fpu block reload on warm restart; from the fpu block
    // upward everything survives, which is what makes warm restart quick
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            for (int i = 0; i < pris_pkg::NUM_WORDS; i++)
            begin
                arch_mem[i] <= pris_pkg::hard_value(i); // RULE_01 RULE_03 RULE_05
            end
            // the table covers RULE_06 RULE_07 RULE_08 RULE_10 RULE_11 RULE_12
            arch_mem[pris_pkg::IDX_FOURTH_GPR] <= SIGNATURE; // RULE_04
            arch_mem[pris_pkg::IDX_ID_SIG] <= SIGNATURE;
            arch_mem[pris_pkg::IDX_VENDOR] <= VENDOR_1; // RULE_17
            arch_mem[pris_pkg::IDX_VENDOR + 7'h01] <= VENDOR_2; // RULE_17
            arch_mem[pris_pkg::IDX_VENDOR + 7'h02] <= VENDOR_3; // RULE_17
            arch_mem[pris_pkg::IDX_SERIAL_OFF] <= {31'h0000_0000, SERIAL_OFF_CFG}; // RULE_16
            // feature mask, power register, a20 unmasked, tsc zero: RULE_14 RULE_15
            // and RULE_18 and RULE_13 come from the same table
        end
        else
        begin
            // tsc runs in every cycle, including the warm restart ones
            {arch_mem[pris_pkg::IDX_TSC_HI], arch_mem[pris_pkg::IDX_TSC_LO]} <=
                {arch_mem[pris_pkg::IDX_TSC_HI], arch_mem[pris_pkg::IDX_TSC_LO]}
                + 64'h0000_0000_0000_0001; // RULE_13
            if (warm_req)
            begin
                for (int i = 0; i < int'(pris_pkg::IDX_FPU_STK); i++)
                begin
                    arch_mem[i] <= pris_pkg::hard_value(i); // RULE_01 RULE_03 RULE_05
                end
                arch_mem[pris_pkg::IDX_FOURTH_GPR] <=
                    {16'h0000, arch_mem[pris_pkg::IDX_ID_SIG][15:0]}; // RULE_04
                arch_mem[pris_pkg::IDX_CR0] <=
                    (pris_pkg::CR0_HARD & ~pris_pkg::CR0_KEEP_MASK)
                    | (arch_mem[pris_pkg::IDX_CR0] & pris_pkg::CR0_KEEP_MASK); // RULE_09
            end
            else if (wr_ok && wr_req_reg.idx < 7'(pris_pkg::NUM_WORDS))
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (wr_req_reg.strb[b])
                    begin
                        arch_mem[wr_req_reg.idx][8*b +: 8] <= wr_req_reg.data[8*b +: 8];
                    end
                end
            end
        end
    end

    // cpu mode is real after either reset kind; it gates code segment writes
    always_ff @(posedge CLK)
    begin
        if (!RST_N || warm_req)
        begin
            mode_reg <= pris_pkg::MODE_REAL;
        end
        else if (wr_ok && wr_req_reg.idx == pris_pkg::IDX_MODE && wr_req_reg.strb[0])
        begin
            mode_reg <= wr_req_reg.data[1:0];
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    assign wr_fire = ~awready_reg & ~wready_reg & ~bvalid_reg;
    assign cs_hit = wr_req_reg.idx >= pris_pkg::IDX_CS && wr_req_reg.idx < pris_pkg::IDX_SEG_DATA;
    // a write that meets a restart is dropped and answered with an error
    assign wr_ok = wr_fire & ~warm_req & wr_req_reg.in_range
        & ((wr_req_reg.idx < 7'(pris_pkg::NUM_WORDS)
            & ~(cs_hit & mode_reg == pris_pkg::MODE_PROT)) // RULE_20
           | wr_req_reg.idx == pris_pkg::IDX_MODE);

    // address and data are taken in either order and held until the response
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= pris_pkg::RESP_OKAY;
            wr_req_reg <= '0;
        end
        else
        begin
            if (AWVALID && awready_reg)
            begin
                wr_req_reg.idx <= AWADDR[8:2];
                wr_req_reg.in_range <= AWADDR[31:9] == 23'h00_0000;
                awready_reg <= 1'b0;
            end
            if (WVALID && wready_reg)
            begin
                wr_req_reg.data <= WDATA;
                wr_req_reg.strb <= WSTRB;
                wready_reg <= 1'b0;
            end
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? pris_pkg::RESP_OKAY : pris_pkg::RESP_SLVERR;
            end
            if (bvalid_reg && BREADY)
            begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    assign rd_idx = ARADDR[8:2];
    assign rd_in_range = ARADDR[31:9] == 23'h00_0000;
    assign status_word = {28'h000_0000, state_reg, A20_MASKED, fetch_en_reg};

    // read mux; unmapped words answer zero with an error
    always_comb
    begin
        rd_value = 32'h0000_0000;
        rd_hit = rd_in_range;
        if (rd_idx < 7'(pris_pkg::NUM_WORDS)) rd_value = arch_mem[rd_idx];
        else if (rd_idx == pris_pkg::IDX_MODE) rd_value = {30'h0000_0000, mode_reg};
        else if (rd_idx == pris_pkg::IDX_STATUS) rd_value = status_word;
        else rd_hit = 1'b0;
        if (!rd_in_range) rd_value = 32'h0000_0000;
    end

    // one read outstanding: arready drops while the data waits for rready
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= pris_pkg::RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end
        else if (ARVALID && arready_reg)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_value;
            rresp_reg <= rd_hit ? pris_pkg::RESP_OKAY : pris_pkg::RESP_SLVERR;
        end
        else if (rvalid_reg && RREADY)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------------------------------
    assign FETCH_EN = fetch_en_reg;
    assign A20_MASKED = arch_mem[pris_pkg::IDX_A20][0]; // RULE_18
    assign CACHE_INV = cache_inv_reg;
    assign TLB_INV = tlb_inv_reg;
    assign AWREADY = awready_reg;
    assign WREADY = wready_reg;
    assign BVALID = bvalid_reg;
    assign BRESP = bresp_reg;
    assign ARREADY = arready_reg;
    assign RVALID = rvalid_reg;
    assign RRESP = rresp_reg;
    assign RDATA = rdata_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_restart;
        warm_req;
    endsequence
    sequence s_release;
        s_restart ##1 !warm_req;
    endsequence

    property p_hard_values;
        !$past(RST_N) |-> arch_mem[pris_pkg::IDX_IP] == pris_pkg::IP_RESET
            && arch_mem[pris_pkg::IDX_CR0] == pris_pkg::CR0_HARD
            && arch_mem[pris_pkg::IDX_FPU_TAG] == pris_pkg::FPU_TAG_RESET
            && arch_mem[pris_pkg::IDX_FOURTH_GPR] == SIGNATURE && !FETCH_EN && CACHE_INV;
    endproperty
    a_hard_values: assert property (p_hard_values) else $error("hard reset values wrong"); // RULE_01

    property p_warm_gpr_ip;
        s_restart |=> arch_mem[0] == 32'h0000_0000
            && arch_mem[pris_pkg::IDX_IP] == pris_pkg::IP_RESET
            && arch_mem[pris_pkg::IDX_FLAGS] == pris_pkg::FLAGS_RESET
            && arch_mem[pris_pkg::IDX_CS] == {pris_pkg::AR_CS, pris_pkg::SEL_CS};
    endproperty
    a_warm_gpr_ip: assert property (p_warm_gpr_ip) else $error("warm load wrong"); // RULE_05

    property p_warm_fourth;
        s_restart |=> arch_mem[pris_pkg::IDX_FOURTH_GPR]
            == {16'h0000, $past(arch_mem[pris_pkg::IDX_ID_SIG][15:0])};
    endproperty
    a_warm_fourth: assert property (p_warm_fourth) else $error("fourth gpr wrong"); // RULE_04

    property p_warm_cr0;
        s_restart |=> arch_mem[pris_pkg::IDX_CR0][28:0] == 29'h0000_0010
            && arch_mem[pris_pkg::IDX_CR0][31] == 1'b0
            && arch_mem[pris_pkg::IDX_CR0][30:29] == $past(arch_mem[pris_pkg::IDX_CR0][30:29]);
    endproperty
    a_warm_cr0: assert property (p_warm_cr0) else $error("cr0 warm value wrong"); // RULE_09

    property p_warm_keeps;
        s_restart |=> $stable(arch_mem[pris_pkg::IDX_FPU_CWSW])
            && $stable(arch_mem[pris_pkg::IDX_FEAT_MASK])
            && $stable(arch_mem[pris_pkg::IDX_POWER])
            && $stable(arch_mem[pris_pkg::IDX_VENDOR]) && $stable(A20_MASKED);
    endproperty
    a_warm_keeps: assert property (p_warm_keeps) else $error("warm changed kept state"); // RULE_12

    property p_tsc_runs;
        s_restart |=> {arch_mem[pris_pkg::IDX_TSC_HI], arch_mem[pris_pkg::IDX_TSC_LO]}
            == $past({arch_mem[pris_pkg::IDX_TSC_HI], arch_mem[pris_pkg::IDX_TSC_LO]})
            + 64'h0000_0000_0000_0001;
    endproperty
    a_tsc_runs: assert property (p_tsc_runs) else $error("tsc stopped in restart"); // RULE_13

    property p_fetch_gate;
        (s_restart |=> !FETCH_EN) and (s_release |=> FETCH_EN);
    endproperty
    a_fetch_gate: assert property (p_fetch_gate) else $error("fetch gating wrong"); // RULE_21

    property p_inval;
        s_restart |=> TLB_INV && !CACHE_INV;
    endproperty
    a_inval: assert property (p_inval) else $error("invalidate outputs wrong"); // RULE_19

    property p_cs_refused;
        wr_fire && !warm_req && cs_hit && mode_reg == pris_pkg::MODE_PROT
            |=> BRESP == pris_pkg::RESP_SLVERR && BVALID
            && $stable(arch_mem[pris_pkg::IDX_CS + 7'h01]);
    endproperty
    a_cs_refused: assert property (p_cs_refused) else $error("cs write not refused"); // RULE_20

endmodule

`default_nettype wire

/* test/pris_chipset.sv */
/*
 * pris_chipset: chipset model that drives the hard reset and warm restart
 * inputs of the processor state block.
 * assumes: the bench owns CLK and calls drive() to change one level.
 */
`timescale 1ns/10ps
`default_nettype none
module pris_chipset (
    input wire logic CLK,
    output logic RST_N,
    output logic WARM_RESTART
);
    // reset is asserted from time zero so no request can come before it
    initial RST_N = 1'b0;
    initial WARM_RESTART = 1'b0;
    // levels change just after an edge, never on the sampling edge
    task automatic drive(input bit warm, input logic v);
        @(posedge CLK);
        if (warm) WARM_RESTART <= v;
        else RST_N <= v;
    endtask
endmodule
`default_nettype wire

/* test/tb_processor_reset_init_state.sv */
/*
 * tb_processor_reset_init_state: bus-level tests of pris_top.
 * assumes: pris_chipset drives the reset levels; the bench masters the bus.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_processor_reset_init_state;
    localparam logic [31:0] SIG = 32'h0000_0bcd; // arbitrary value
    localparam logic [31:0] V1 = 32'h5a5a_0001; // arbitrary value
    localparam logic [31:0] Z = 32'h0;
    localparam logic [31:0] F = 32'hffff_ffff;
    localparam logic [38:0] HV [20] = '{{7'h00, Z}, {7'h03, SIG}, {7'h08, 32'h0000_fff0},
        {7'h09, 32'h0000_0002}, {7'h0a, 32'h009b_f000}, {7'h0b, 32'hffff_0000},
        {7'h0c, 32'h0000_ffff}, {7'h0d, 32'h0093_0000}, {7'h1d, 32'h0000_ffff},
        {7'h20, 32'h0082_0000}, {7'h26, 32'h6000_0010}, {7'h27, Z}, {7'h2f, 32'h0000_0400},
        {7'h30, Z}, {7'h58, 32'h0000_0040}, {7'h59, 32'h0000_5555}, {7'h60, Z}, {7'h63, V1},
        {7'h66, 32'hffff_feff}, {7'h68, 32'h0000_0064}};
    localparam logic [38:0] WV [18] = '{{7'h00, Z}, {7'h03, 32'h0000_ffff},
        {7'h08, 32'h0000_fff0}, {7'h0a, 32'h009b_f000}, {7'h12, 32'h0000_ffff}, {7'h1c, Z},
        {7'h25, 32'h0000_ffff}, {7'h26, 32'h6000_0010}, {7'h29, Z}, {7'h2e, 32'hffff_0ff0},
        {7'h30, F}, {7'h48, F}, {7'h58, F}, {7'h60, F}, {7'h62, F}, {7'h63, F}, {7'h66, F},
        {7'h67, F}};
    logic CLK = 1'b0;
    logic SHUTDOWN = 1'b0, SERIAL_OFF_CFG = 1'b1, AWVALID = 1'b0, WVALID = 1'b0;
    logic BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic [3:0] WSTRB = 4'hf;
    logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0, RDATA;
    logic RST_N, WARM_RESTART, FETCH_EN, A20_MASKED, CACHE_INV, TLB_INV;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [1:0] BRESP, RRESP;
    int fails = 0, n_tests = 0, cyc = 0;
    // 50 ns period
    always #25 CLK = ~CLK;
    pris_chipset u_cs (.CLK(CLK), .RST_N(RST_N), .WARM_RESTART(WARM_RESTART));
    pris_top #(.SIGNATURE(SIG), .VENDOR_1(V1)) DUT (.CLK(CLK), .RST_N(RST_N),
        .WARM_RESTART(WARM_RESTART), .SHUTDOWN(SHUTDOWN), .SERIAL_OFF_CFG(SERIAL_OFF_CFG),
        .FETCH_EN(FETCH_EN), .A20_MASKED(A20_MASKED), .CACHE_INV(CACHE_INV),
        .TLB_INV(TLB_INV), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // address and data offered together; each released at its own take
    task automatic wr(input logic [6:0] i, input logic [31:0] d, input logic [1:0] er);
        @(posedge CLK);
        AWADDR <= {23'h0, i, 2'h0};
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do
        begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (BVALID !== 1'b1);
        BREADY <= 1'b0;
        chk($sformatf("bresp %h", i), {30'h0, er}, {30'h0, BRESP});
    endtask
    task automatic rd(input logic [6:0] i, input logic [31:0] e, input logic [1:0] er);
        @(posedge CLK);
        ARADDR <= {23'h0, i, 2'h0};
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do
        begin
            @(posedge CLK);
            if (ARREADY) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1);
        RREADY <= 1'b0;
        chk($sformatf("word %h", i), e, RDATA);
        chk($sformatf("rresp %h", i), {30'h0, er}, {30'h0, RRESP});
    endtask
    task automatic hard_seq();
        u_cs.drive(1'b0, 1'b0);
        repeat (3) @(posedge CLK);
        #1;
        chk("reset pins", 32'h6, {29'h0, CACHE_INV, TLB_INV, FETCH_EN});
        u_cs.drive(1'b0, 1'b1);
        @(posedge CLK);
        #1;
        chk("run pins", 32'h1, {28'h0, CACHE_INV, TLB_INV, A20_MASKED, FETCH_EN});
        foreach (HV[k]) rd(HV[k][38:32], HV[k][31:0], 2'h0);
        rd(7'h61, {31'h0, SERIAL_OFF_CFG}, 2'h0);
    endtask
    // dirty the a20 word and every word in WV, restart, then see which words were reloaded
    task automatic restart(input bit sd);
        wr(7'h69, 32'h1, 2'h0);
        foreach (WV[k]) wr(WV[k][38:32], F, 2'h0);
        SERIAL_OFF_CFG <= 1'b0;
        u_cs.drive(1'b1, !sd);
        // shutdown rises on the same edge the warm pin would, so both share one check
        SHUTDOWN <= sd;
        u_cs.drive(1'b1, 1'b0);
        SHUTDOWN <= 1'b0;
        #1;
        chk("restart pins", 32'h6, {28'h0, CACHE_INV, TLB_INV, A20_MASKED, FETCH_EN});
        @(posedge CLK);
        #1;
        chk("fetch", 32'h1, {31'h0, FETCH_EN});
        foreach (WV[k]) rd(WV[k][38:32], WV[k][31:0], 2'h0);
        rd(7'h61, 32'h1, 2'h0);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // the run needs about 450 cycles; a hang is cut well beyond that
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            print_verdict();
        end
    end
    initial
    begin
        hard_seq();
        restart(1'b0);
        restart(1'b1);
        wr(7'h6b, Z, 2'h2);
        rd(7'h6b, 32'h0000_000b, 2'h0);
        rd(7'h70, Z, 2'h2);
        for (int m = 2; m >= 0; m--)
        begin
            wr(7'h6a, 32'(m), 2'h0);
            wr(7'h0b, 32'h1234_0000 + 32'(m), (m == 2) ? 2'h2 : 2'h0);
            rd(7'h0b, (m == 2) ? 32'hffff_0000 : 32'h1234_0000 + 32'(m), 2'h0);
        end
        hard_seq();
        print_verdict();
    end
endmodule
`default_nettype wire
